// File: rtl/sps_pkg.sv
// Package for the priority source status block: register map, field layout,
// reset values and channel encoding.
// Assumes byte addressing on a 32-bit APB with one register per aligned word.
package sps_pkg;

  // Number of reference inputs and width of one channel code.
  localparam int N_INPUTS = 14;
  localparam int CHAN_W = 4;
  localparam int PRIO_W = 4;
  localparam int RANKS = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_TOP_SEL = 8'h09;
  localparam logic [7:0] IDX_TABLE_HIGH = 8'h0B;
  localparam logic [7:0] IDX_ALLOW_LOW = 8'h30;
  localparam logic [7:0] IDX_ALLOW_HIGH = 8'h31;

  localparam logic [7:0] ADDR_TOP_SEL = {IDX_TOP_SEL[5:0], 2'b00};
  localparam logic [7:0] ADDR_TABLE_HIGH = {IDX_TABLE_HIGH[5:0], 2'b00};
  localparam logic [7:0] ADDR_ALLOW_LOW = {IDX_ALLOW_LOW[5:0], 2'b00};
  localparam logic [7:0] ADDR_ALLOW_HIGH = {IDX_ALLOW_HIGH[5:0], 2'b00};

  // Field positions inside the top and selected source register.
  localparam int TOP_LSB = 4;
  localparam int SEL_LSB = 0;

  // Bit position of the high byte of the validated priority table.
  localparam int TABLE_HIGH_LSB = 8;

  // Reset values.
  localparam logic [7:0] RST_TOP_SEL = 8'h00;
  localparam logic [7:0] RST_TABLE_HIGH = 8'h00;
  localparam logic [7:0] RST_ALLOW_LOW = 8'hFF;
  localparam logic [7:0] RST_ALLOW_HIGH = 8'h3F;

  // Channel code meaning no validated source; code k names input k.
  localparam logic [CHAN_W-1:0] CHAN_NONE = 4'h0;

  // Priority value that keeps an input out of the ranking.
  localparam logic [PRIO_W-1:0] PRIO_OFF = 4'h0;

endpackage

// File: rtl/sps_rank_if.sv
// Interface carrying the ranking request and result between the status
// register bank and its ranking engine.
// Assumes both ends run in the same clock domain; the path is combinational.
`timescale 1ns/100ps
`default_nettype none
interface sps_rank_if;
  import sps_pkg::*;

  // Inputs that are both valid and allowed.
  logic [N_INPUTS-1:0] eligible;
  // Priority of each input, four bits per input, input one lowest.
  logic [N_INPUTS*PRIO_W-1:0] prio;
  // Ranked channel codes, rank zero in the lowest nibble.
  logic [RANKS*CHAN_W-1:0] table_out;

  modport bank (output eligible, output prio, input table_out);
  modport engine (input eligible, input prio, output table_out);
endinterface
`default_nettype wire

// File: rtl/sps_ranker.sv
// Ranking engine: orders eligible inputs by priority into a table of four
// channel codes.
// Assumes the caller has already removed invalid and disallowed inputs.
`timescale 1ns/100ps
`default_nettype none
module sps_ranker (
  sps_rank_if.engine rank // Ranking request and result.
);
  import sps_pkg::*;

  // Pick the best remaining input once per rank; lower priority value wins,
  // a tie goes to the lower channel. Four passes cost a deep path, but the
  // result only feeds registers that are refreshed every cycle.
  always_comb begin
    logic [N_INPUTS-1:0] taken;
    logic [CHAN_W-1:0] best;
    logic [PRIO_W:0] best_prio;
    logic [PRIO_W-1:0] p;
    int best_idx;
    taken = '0;
    best = CHAN_NONE;
    best_prio = '0;
    p = '0;
    best_idx = 0;
    rank.table_out = '0;
    for (int r = 0; r < RANKS; r++) begin
      best = CHAN_NONE;
      best_prio = {1'b1, {PRIO_W{1'b0}}};
      best_idx = 0;
      for (int i = 0; i < N_INPUTS; i++) begin
        p = rank.prio[i*PRIO_W +: PRIO_W];
        // Disallowed inputs never reach the eligible set.
        if (rank.eligible[i] && !taken[i] && p != PRIO_OFF
            && {1'b0, p} < best_prio) begin
          best = CHAN_W'(i + 1); // Input one is code one.
          best_prio = {1'b0, p};
          best_idx = i;
        end
      end
      if (best != CHAN_NONE) begin
        taken[best_idx] = 1'b1;
      end
      rank.table_out[r*CHAN_W +: CHAN_W] = best; // Zero when none.
    end
  end
endmodule
`default_nettype wire

// File: rtl/sps_status.sv
// Priority source status register bank for the second clock path: reports
// the highest-priority validated source, the selected source and the high
// byte of the validated priority table over APB.
// Assumes valid flags, priorities and the selected channel come from logic
// on pclk, so they are read without synchronisers.
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Bits 7:4 report highest-priority validated input
// - Zero means none; code k is input k
// - Disallowed valid inputs never enter the ranking
// - Bits 3:0 report currently selected input
// - Selected field: code k is input k
// - Read-only table high byte, resets zero
module sps_status (
  input wire logic pclk, // System clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write byte strobes.
  output logic [31:0] prdata, // APB read data, registered.
  output logic pready, // APB ready, no wait states.
  output logic pslverr, // APB error for unmapped addresses, registered.
  input wire logic [sps_pkg::N_INPUTS-1:0] valid_in, // Per-input validated flag.
  input wire logic [sps_pkg::N_INPUTS*sps_pkg::PRIO_W-1:0] prio_in, // Priorities.
  input wire logic [sps_pkg::CHAN_W-1:0] selected_chan, // Selector's current input.
  output logic [sps_pkg::CHAN_W-1:0] top_chan // Registered highest validated input.
);
  import sps_pkg::*;

  sps_rank_if rank_bus ();

  logic [7:0] top_sel;
  logic [7:0] table_high;
  logic [7:0] allow_low;
  logic [7:0] allow_high;
  logic [7:0] next_top_sel;
  logic [7:0] next_table_high;
  logic [7:0] next_allow_low;
  logic [7:0] next_allow_high;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [15:0] allow_mask;
  logic setup_phase;
  logic access_wr;

  // The allow registers hold one bit per input, input one in bit zero.
  assign allow_mask = {allow_high, allow_low};
  assign rank_bus.eligible = valid_in & allow_mask[N_INPUTS-1:0];
  assign rank_bus.prio = prio_in;

  sps_ranker u_ranker (
    .rank(rank_bus.engine)
  );

  // Status is refreshed every cycle so reads always see live values.
  always_comb begin
    next_top_sel = {rank_bus.table_out[0 +: CHAN_W], selected_chan};
    next_table_high = rank_bus.table_out[TABLE_HIGH_LSB +: 8];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_sel <= RST_TOP_SEL;
      table_high <= RST_TABLE_HIGH;
    end else begin
      top_sel <= next_top_sel;
      table_high <= next_table_high;
    end
  end

  assign top_chan = top_sel[TOP_LSB +: CHAN_W];

  // Zero wait states: data is fetched in the setup cycle and the access
  // cycle always completes, which keeps the slave free of any state machine.
  assign setup_phase = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign pready = psel && penable;

  // Only the allow registers accept writes; status writes fall away.
  always_comb begin
    next_allow_low = allow_low;
    next_allow_high = allow_high;
    if (access_wr && pstrb[0]) begin
      if (paddr == ADDR_ALLOW_LOW) begin
        next_allow_low = pwdata[7:0];
      end else if (paddr == ADDR_ALLOW_HIGH) begin
        next_allow_high = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      allow_low <= RST_ALLOW_LOW;
      allow_high <= RST_ALLOW_HIGH;
    end else begin
      allow_low <= next_allow_low;
      allow_high <= next_allow_high;
    end
  end

  // Read decode in the setup cycle; reads change no state.
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup_phase) begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (paddr == ADDR_TOP_SEL) begin
        next_prdata[7:0] = top_sel;
      end else if (paddr == ADDR_TABLE_HIGH) begin
        next_prdata[7:0] = table_high;
      end else if (paddr == ADDR_ALLOW_LOW) begin
        next_prdata[7:0] = allow_low;
      end else if (paddr == ADDR_ALLOW_HIGH) begin
        next_prdata[7:0] = allow_high;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end
endmodule
`default_nettype wire

// File: test/sps_status_properties.sv
// Checker for the priority source status bank, bound to its ports.
// Assumes no APB wait states and status registers one cycle behind inputs.
`timescale 1ns/100ps
`default_nettype none
module sps_status_properties (
  input wire logic pclk, presetn, psel, penable, pwrite, // Clock, reset, APB controls.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, prdata, // APB data.
  input wire logic [3:0] pstrb, // Byte strobes.
  input wire logic pready, pslverr, // APB answer.
  input wire logic [sps_pkg::N_INPUTS-1:0] valid_in, // Validated flags.
  input wire logic [sps_pkg::N_INPUTS*sps_pkg::PRIO_W-1:0] prio_in, // Priorities.
  input wire logic [sps_pkg::CHAN_W-1:0] selected_chan, top_chan // Channel codes.
);
  import sps_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [N_INPUTS-1:0] vq;
  logic [N_INPUTS*PRIO_W-1:0] pq;
  // Last cycle's inputs, so a reported winner can be checked against its cause.
  always_ff @(posedge pclk) begin
    vq <= valid_in;
    pq <= prio_in;
  end
  // Read data is valid only in the access cycle.
  wire logic rd = psel && penable && !pwrite;
  wire logic map = paddr inside {ADDR_TOP_SEL, ADDR_TABLE_HIGH, ADDR_ALLOW_LOW, ADDR_ALLOW_HIGH};
  a_ready_follows: assert property (pready == (psel && penable)) else $error("ready wrong");
  a_top_field: assert property (
    rd && paddr == 8'h24 |-> prdata[7:4] == $past(top_chan)) else $error("top field wrong");
  a_sel_field: assert property (
    $past(presetn, 2) && rd && paddr == 8'h24 |-> prdata[3:0] == $past(selected_chan, 2))
    else $error("selected field wrong");
  a_top_none: assert property (
    $past(valid_in) == '0 |-> top_chan == CHAN_NONE) else $error("top not zero");
  a_top_eligible: assert property (
    top_chan != 0 |-> top_chan <= N_INPUTS && vq[top_chan-1] && pq[4*top_chan-4+:4] != 0)
    else $error("top not eligible");
  a_unmapped_err: assert property (
    psel && penable && !map |-> pslverr && prdata == '0) else $error("no error");
  a_mapped_ok: assert property (
    psel && penable && map |-> !pslverr) else $error("spurious error");
  a_upper_zero: assert property (rd |-> prdata[31:8] == '0) else $error("upper bits set");
  a_table_empty: assert property (
    $past(presetn, 2) && rd && paddr == 8'h2C && $past(valid_in, 2) == '0 |-> prdata[7:0] == '0)
    else $error("table not empty");
  cover property (rd && paddr == 8'h24 && prdata[7:4] != 0);
  cover property (rd && paddr == 8'h2C && prdata[7:0] != 0);
  cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// File: test/sps_status_test.sv
// Testbench for the status bank: random inputs and allow masks against a ranking model.
// Assumes zero-wait APB answers; the checker is bound at the foot.
`timescale 1ns/100ps
`default_nettype none
module sps_status_test;
  import sps_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, r;
  logic [3:0] pstrb = '0, selected_chan = '0, top_chan;
  logic [N_INPUTS-1:0] valid_in = '0;
  logic [N_INPUTS*PRIO_W-1:0] prio_in = '0;
  logic [63:0] r64;
  logic [15:0] al = 16'h3FFF, t;
  int seed = 71, fail_count = 0, num_checks = 0;
  always #5 pclk = ~pclk;
  sps_status i_sps_status (.*);
  // One APB transfer; a dead slave is caught by the watchdog, not by a local count.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task chk(input logic [32:0] s, input logic [32:0] x);
    num_checks++;
    if (s !== x) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, s, x);
    end
  endtask
  // Lowest nonzero priority wins; a tie goes to the lower channel.
  task automatic model();
    int b;
    bit used [N_INPUTS];
    t = '0;
    for (int rk = 0; rk < RANKS; rk++) begin
      b = -1;
      for (int k = 0; k < N_INPUTS; k++)
        if (valid_in[k] && al[k] && prio_in[4*k+:4] != 0 && !used[k]
            && (b < 0 || prio_in[4*k+:4] < prio_in[4*b+:4])) b = k;
      if (b >= 0) begin
        used[b] = 1;
        t[4*rk+:4] = 4'(b + 1);
      end
    end
  endtask
  task report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog well beyond the roughly 1100 cycles the sequence needs.
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  // The reporting-enable configuration bit is software's duty outside this
  // bank; the bench runs as though it were set.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h24, 0);
    chk(q, 0);
    apb(0, 8'h2C, 0);
    chk(q, 0);
    apb(0, 8'hC4, 0);
    chk(q, 32'h3F);
    apb(1, 8'h10, 32'h5A);
    chk(e, 1);
    // Random sources; every eighth round has none valid, and some winners get disallowed.
    for (int i = 0; i < 60; i++) begin
      r64 = {$random(seed), $random(seed)};
      r = $random(seed);
      prio_in <= r64[55:0];
      valid_in <= (i % 8 == 0) ? '0 : r[13:0] | r64[63:50];
      selected_chan <= 4'(r[31:28] % 14 + 1);
      al = r[15:0] | r64[63:48];
      apb(1, 8'hC0, al[7:0]);
      apb(1, 8'hC4, al[15:8]);
      apb(1, 8'h24, r);
      apb(1, 8'h2C, r);
      model();
      apb(0, 8'h24, 0);
      chk(q, {t[3:0], selected_chan});
      chk(top_chan, t[3:0]);
      apb(0, 8'h2C, 0);
      chk(q, t[15:8]);
    end
    report_and_stop();
  end
endmodule
bind sps_status sps_status_properties i_sps_status_properties (.*);
`default_nettype wire
